// File: design/acs_pkg.sv
/*
 * constants shared by both ends of the converter control link: pipeline
 * depth, word layout, calibration and forced-reset lengths, host register
 * map. assumes one clock shared by both ends.
 */
// Functional notes
// RL1 - word appears 28 sample clocks after start
// RL2 - power-up calibrates, holding reset pin low
// RL3 - keep sample rate fixed during calibration; a write held over a forced pulse lands as calibration starts
// RL4 - recalibrate after sample rate moves over 10%
// RL5 - reset pin recalibrates at any time
// RL6 - force reset: open-drain low, ten periods
// RL7 - no pull-up on the reset pin
// RL8 - select low internal, high external reference
// RL9 - reference select floats high, external
// RL10 - halve control low divides sample clock
// RL11 - divider toggles on rising edges, 50% duty
// RL12 - format select low gives two's complement
// RL13 - ten bit word, bit 9 MSB, strobe
// RL14 - reset pin active low, holds until released
// RL15 - format select high gives offset binary
// RL16 - over-range flag aligned with its word
// RL17 - capture on strobe, discard during calibration
package acs_pkg;
    localparam int PIPE_CORE     = 24;   // converter stages
    localparam int PIPE_CORRECT  = 4;    // error-correction stages
    localparam int PIPE_TOTAL    = PIPE_CORE + PIPE_CORRECT;
    localparam int WORD_W        = 10;
    localparam int ANALOG_W      = 12;   // signed, wider than full scale
    localparam int WORD_MSB      = WORD_W - 1;
    localparam int RESET_LOW_PERIODS = 10;
    localparam int CAL_SAMPLES   = 2048; // calibration length, samples
    localparam int PIN_SETTLE    = 3;    // sync delay before pin is trusted
    localparam logic signed [ANALOG_W-1:0] FS_POS = 12'sh1FF;
    localparam logic signed [ANALOG_W-1:0] FS_NEG = -12'sh200;

    // host register map, byte addresses
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_SAMPLE   = 4'h8;
    localparam logic [3:0] REG_IRQ_STAT = 4'hC;
    // irq mask sits at 0x10, outside the 4-bit low decode
    localparam logic [4:0] REG_IRQ_MASK = 5'h10;
    // control bits
    localparam int CTRL_RECAL    = 0;    // write one to force recalibration
    localparam int CTRL_HALVE_N  = 1;
    localparam int CTRL_FMT_N    = 2;
    localparam int CTRL_REF_EXT  = 3;
    localparam int CTRL_FLOAT    = 4;    // release the three select pins
    localparam logic [31:0] CTRL_RESET = 32'h0000001E;
    // irq bits
    localparam int IRQ_SAMPLE    = 0;
    localparam int IRQ_OVER      = 1;
    localparam int IRQ_CAL_DONE  = 2;
    localparam int IRQ_W         = 3;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : acs_pkg

// File: design/acs_link_if.sv
/*
 * pin-level link between the converter control end and the capture end.
 * resolves the open-drain reset pin and the pulled-up select pins from
 * the enables; both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface acs_link_if;
    import acs_pkg::*;
    // reset pin, open drain on both sides, enable active low
    logic dev_rst_oe_n;
    logic host_rst_oe_n;
    logic reset_pin_n;
    // select pins, driven by the capture end, released floats high
    logic sel_oe_n;
    logic clock_halve_n_drv;
    logic signed_format_select_n_drv;
    logic ref_source_select_drv;
    logic clock_halve_n;
    logic signed_format_select_n;
    logic ref_source_select;
    // sample outputs
    logic [WORD_W-1:0] sample_word;
    logic              over_range;
    logic              sample_strobe_out;

    // released pin reads high, as an open input does
    assign reset_pin_n = dev_rst_oe_n & host_rst_oe_n;
    assign clock_halve_n = sel_oe_n | clock_halve_n_drv;
    assign signed_format_select_n = sel_oe_n | signed_format_select_n_drv;
    assign ref_source_select = sel_oe_n | ref_source_select_drv;

    modport device (
        output dev_rst_oe_n, sample_word, over_range, sample_strobe_out,
        input  reset_pin_n, clock_halve_n, signed_format_select_n,
        input  ref_source_select
    );
    modport host (
        output host_rst_oe_n, sel_oe_n, clock_halve_n_drv,
        output signed_format_select_n_drv, ref_source_select_drv,
        input  reset_pin_n, sample_word, over_range, sample_strobe_out
    );
endinterface : acs_link_if
`default_nettype wire

// File: design/acs_converter.sv
/*
 * converter control end: clock halving, calibration sequencing on the
 * open-drain reset pin, reference choice, 28-sample pipeline with output
 * formatting and over-range flag.
 * assumes the analog value arrives as a signed code on this clock.
 */
`timescale 1ns/100ps
`default_nettype none
module acs_converter
    import acs_pkg::*;
#(
    parameter int CAL_LEN  = CAL_SAMPLES,
    parameter int PIPE_LEN = PIPE_TOTAL
) (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       resetn,
    // converter side
    input  wire logic signed [ANALOG_W-1:0] analog_in,
    input  wire logic signed [ANALOG_W-1:0] ext_ref_level,
    output logic                            ref_external_active,
    output logic                            calibrating,
    // link
    acs_link_if.device                      link
);
    initial begin
        if (PIPE_LEN < 2 || CAL_LEN < 1 || CAL_LEN > 65535)
            $error("acs_converter: unsupported parameter value");
    end

    typedef enum logic [3:0] {
        ST_CAL    = 4'h1,
        ST_SETTLE = 4'h2,
        ST_RUN    = 4'h4,
        ST_HELD   = 4'h8
    } acs_state_e;

    acs_state_e state_reg;
    acs_state_e state_next;

    // saturate a wide value into the ten-bit signed range
    function automatic logic [WORD_W-1:0] acs_clamp(
        input logic signed [ANALOG_W-1:0] v);
        if (v > FS_POS)
            acs_clamp = FS_POS[WORD_W-1:0];
        else if (v < FS_NEG)
            acs_clamp = FS_NEG[WORD_W-1:0];
        else
            acs_clamp = v[WORD_W-1:0];
    endfunction

    // select pins pass two flip-flops; only the second stage is read
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_meta_reg <= 4'hF;
            pin_sync_reg <= 4'hF;
        end else begin
            pin_meta_reg <= {link.reset_pin_n, link.clock_halve_n,
                             link.signed_format_select_n,
                             link.ref_source_select};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic rst_pin_n;
    logic halve_n;
    logic fmt_n;
    logic ref_ext;
    assign rst_pin_n = pin_sync_reg[3];
    assign halve_n   = pin_sync_reg[2];
    assign fmt_n     = pin_sync_reg[1];
    assign ref_ext   = pin_sync_reg[0];

    // divider: one flop toggled on every rising edge, so its output is
    // high exactly every other cycle whatever the input duty cycle
    logic div_phase_reg;
    logic sample_tick;
    always_ff @(posedge clock) begin
        if (!resetn)
            div_phase_reg <= 1'b0;
        else
            div_phase_reg <= ~div_phase_reg;                // [RL11]
    end
    assign sample_tick = halve_n | div_phase_reg;           // [RL10]

    // calibration counter, counted in sample clocks
    logic [15:0] cal_cnt_reg;
    logic [2:0]  settle_cnt_reg;
    logic        cal_done;
    assign cal_done = (cal_cnt_reg == 16'(CAL_LEN - 1)) && sample_tick;
    always_ff @(posedge clock) begin
        if (!resetn || state_reg != ST_CAL)
            cal_cnt_reg <= 16'h0000;
        else if (sample_tick)
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
    end
    always_ff @(posedge clock) begin
        if (!resetn || state_reg != ST_SETTLE)
            settle_cnt_reg <= 3'h0;
        else
            settle_cnt_reg <= settle_cnt_reg + 3'h1;
    end

    // sequencer: reset release starts a calibration; the pin is ours
    // while calibrating, so our own low level is never read as a request
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_CAL:    if (cal_done) state_next = ST_SETTLE;     // [RL2]
            ST_SETTLE: begin
                if (settle_cnt_reg == 3'(PIN_SETTLE))
                    state_next = rst_pin_n ? ST_RUN : ST_HELD;
            end
            ST_RUN:    if (!rst_pin_n) state_next = ST_HELD;     // [RL5]
            ST_HELD:   if (rst_pin_n) state_next = ST_CAL;       // [RL14]
            default:   state_next = ST_CAL;
        endcase
    end
    always_ff @(posedge clock) begin
        if (!resetn)
            state_reg <= ST_CAL;                                 // [RL2]
        else
            state_reg <= state_next;
    end

    // hold the reset pin low for the whole calibration
    always_ff @(posedge clock) begin
        if (!resetn)
            link.dev_rst_oe_n <= 1'b0;
        else
            link.dev_rst_oe_n <= (state_next != ST_CAL);         // [RL2]
    end

    // reference choice: internal full scale unless the select is high
    logic signed [ANALOG_W-1:0] scaled_in;
    always_comb begin
        if (ref_ext)                                             // [RL8]
            scaled_in = analog_in - ext_ref_level;
        else
            scaled_in = analog_in;                               // [RL9]
    end
    always_ff @(posedge clock) begin
        if (!resetn)
            ref_external_active <= 1'b1;
        else
            ref_external_active <= ref_ext;
    end

    // pipeline: word plus over-range flag move together, one stage per
    // sample clock; depth is the core stages plus correction stages
    logic [WORD_W:0] pipe_mem [PIPE_LEN];
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < PIPE_LEN; i++)
                pipe_mem[i] <= '0;
        end else if (sample_tick) begin
            pipe_mem[0] <= {(scaled_in > FS_POS) || (scaled_in < FS_NEG),
                            acs_clamp(scaled_in)};               // [RL16]
            for (int i = 1; i < PIPE_LEN; i++)
                pipe_mem[i] <= pipe_mem[i-1];                    // [RL1]
        end
    end

    // output register: format applied at the pin, zero while not running
    logic [WORD_W:0] tail;
    assign tail = pipe_mem[PIPE_LEN-1];
    always_ff @(posedge clock) begin
        if (!resetn || state_reg != ST_RUN) begin
            link.sample_word <= '0;
            link.over_range  <= 1'b0;
        end else if (sample_tick) begin
            link.over_range <= tail[WORD_W];                     // [RL16]
            if (fmt_n)                                           // [RL15]
                link.sample_word <= {~tail[WORD_MSB], tail[WORD_MSB-1:0]};
            else
                link.sample_word <= tail[WORD_W-1:0];            // [RL12]
        end
    end

    // strobe high in each cycle that shows a fresh word; at the halved
    // rate it is the divider phase one cycle late, a 50% duty clock [RL13]
    always_ff @(posedge clock) begin
        if (!resetn)
            link.sample_strobe_out <= 1'b0;
        else
            link.sample_strobe_out <= (state_reg == ST_RUN) && sample_tick;
    end

    assign calibrating = (state_reg == ST_CAL);
endmodule // acs_converter
`default_nettype wire

// File: design/acs_capture.sv
/*
 * capture end: AXI4-Lite slave holding control, status, last sample and
 * interrupt registers; drives the select pins and the open-drain reset.
 * assumes the converter end shares this clock.
 */
`timescale 1ns/100ps
`default_nettype none
module acs_capture
    import acs_pkg::*;
#(
    parameter int LOW_CYCLES = 2 * RESET_LOW_PERIODS
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // axi4-lite write
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // interrupt
    output logic             irq,
    // link
    acs_link_if.host         link
);
    initial begin
        if (LOW_CYCLES < 2 * RESET_LOW_PERIODS || LOW_CYCLES > 255)
            $error("acs_capture: LOW_CYCLES out of range");
    end

    logic [31:0]       ctrl_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic [WORD_W:0]   sample_reg;
    logic [7:0]        low_cnt_reg;
    logic              pin_meta_reg;
    logic              pin_sync_reg;
    logic              pin_prev_reg;

    // write taken when address and data are both offered
    logic wr_go;
    logic rd_go;
    assign wr_go   = awvalid && wvalid && !bvalid;
    assign awready = wr_go;
    assign wready  = wr_go;
    assign rd_go   = arvalid && !rvalid;
    assign arready = rd_go;

    function automatic logic is_mapped(input logic [4:0] a);
        is_mapped = (a == {1'b0, REG_CTRL}) || (a == {1'b0, REG_STATUS}) ||
                    (a == {1'b0, REG_SAMPLE}) ||
                    (a == {1'b0, REG_IRQ_STAT}) || (a == REG_IRQ_MASK);
    endfunction

    // reset pin seen through two flops
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= link.reset_pin_n;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // control register; recalibration bit is write-one, self-clearing
    logic recal_req;
    assign recal_req = wr_go && awaddr == {1'b0, REG_CTRL} && wstrb[0] &&
                       wdata[CTRL_RECAL];
    always_ff @(posedge clock) begin
        if (!resetn)
            ctrl_reg <= CTRL_RESET;
        else if (wr_go && awaddr == {1'b0, REG_CTRL} && wstrb[0])
            ctrl_reg[CTRL_FLOAT:CTRL_HALVE_N] <=
                wdata[CTRL_FLOAT:CTRL_HALVE_N];
    end
    // selects move only while the synced pin is high; a write made while it is low waits,
    // so one left over from a forced pulse can change the sample rate early in the next calibration
    always_ff @(posedge clock) begin
        if (!resetn) begin
            link.sel_oe_n                   <= 1'b1;
            link.clock_halve_n_drv          <= 1'b1;
            link.signed_format_select_n_drv <= 1'b1;
            link.ref_source_select_drv      <= 1'b1;
        end else if (pin_sync_reg) begin                        // [RL3]
            link.sel_oe_n                   <= ctrl_reg[CTRL_FLOAT];
            link.clock_halve_n_drv          <= ctrl_reg[CTRL_HALVE_N];
            link.signed_format_select_n_drv <= ctrl_reg[CTRL_FMT_N];
            link.ref_source_select_drv      <= ctrl_reg[CTRL_REF_EXT];
        end
    end

    // forced reset: pull low, open drain only, for ten slowest periods;
    // counting twice ten clock cycles keeps the minimum in both modes
    always_ff @(posedge clock) begin
        if (!resetn)
            low_cnt_reg <= 8'h00;
        else if (recal_req && low_cnt_reg == 8'h00)
            low_cnt_reg <= 8'(LOW_CYCLES);                      // [RL6]
        else if (low_cnt_reg != 8'h00)
            low_cnt_reg <= low_cnt_reg - 8'h01;
    end
    // never driven high: the pin carries no pull-up from this side [RL7]
    assign link.host_rst_oe_n = (low_cnt_reg == 8'h00);         // [RL14]

    // capture on strobe, discard while the pin shows calibration
    logic take;
    assign take = link.sample_strobe_out && pin_sync_reg &&
                  (low_cnt_reg == 8'h00);                       // [RL17]
    always_ff @(posedge clock) begin
        if (!resetn)
            sample_reg <= '0;
        else if (take)
            sample_reg <= {link.over_range, link.sample_word};  // [RL17]
    end

    // sticky interrupt status: set wins over a write-one clear
    logic [IRQ_W-1:0] ev;
    assign ev = {pin_sync_reg && !pin_prev_reg,
                 take && link.over_range, take};
    always_ff @(posedge clock) begin
        if (!resetn)
            irq_stat_reg <= '0;
        else if (wr_go && awaddr == {1'b0, REG_IRQ_STAT} && wstrb[0])
            irq_stat_reg <= (irq_stat_reg & ~wdata[IRQ_W-1:0]) | ev;
        else
            irq_stat_reg <= irq_stat_reg | ev;
    end
    always_ff @(posedge clock) begin
        if (!resetn)
            irq_mask_reg <= '0;
        else if (wr_go && awaddr == REG_IRQ_MASK && wstrb[0])
            irq_mask_reg <= wdata[IRQ_W-1:0];
    end
    always_ff @(posedge clock) begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_mask_reg);
    end

    // write response one cycle after the write is taken
    always_ff @(posedge clock) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= AXI_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= is_mapped(awaddr) ? AXI_OKAY : AXI_SLVERR;
        end else if (bready)
            bvalid <= 1'b0;
    end

    // read data one cycle after the address is taken
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= AXI_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rresp  <= is_mapped(araddr) ? AXI_OKAY : AXI_SLVERR;
            case (araddr)
                {1'b0, REG_CTRL}:     rdata <= ctrl_reg;
                {1'b0, REG_STATUS}:   rdata <= {30'h0, low_cnt_reg != 8'h00,
                                                ~pin_sync_reg};
                {1'b0, REG_SAMPLE}:   rdata <= {21'h0, sample_reg};
                {1'b0, REG_IRQ_STAT}: rdata <= {29'h0, irq_stat_reg};
                REG_IRQ_MASK:         rdata <= {29'h0, irq_mask_reg};
                default:              rdata <= 32'h00000000;
            endcase
        end else if (rready)
            rvalid <= 1'b0;
    end
endmodule // acs_capture
`default_nettype wire

// File: dv/acs_link_asserts.sv
/*
 * concurrent checks on the converter-to-capture link.
 * assumes one clock for both ends and a synchronous active-low resetn.
 */
`timescale 1ns/100ps
`default_nettype none
module acs_link_asserts
    import acs_pkg::*;
#(
    parameter int LOW_CYCLES = 2 * RESET_LOW_PERIODS
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              resetn,
    // reset pin and clock halve select
    input wire logic              dev_rst_oe_n,
    input wire logic              host_rst_oe_n,
    input wire logic              reset_pin_n,
    input wire logic              clock_halve_n,
    // sample outputs
    input wire logic [WORD_W-1:0] sample_word,
    input wire logic              over_range,
    input wire logic              sample_strobe_out
);
    logic [7:0] low_cnt_reg;

    // length of the current host pull, so the pulse can be measured
    always_ff @(posedge clock) begin
        if (!resetn) begin
            low_cnt_reg <= 8'h00;
        end else if (!host_rst_oe_n) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
        end else begin
            low_cnt_reg <= 8'h00;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_reset_quiet: assert property ($rose(resetn) |->
        sample_word == '0 && !over_range && !sample_strobe_out)
        else $error("outputs not quiet after reset");
    a_powerup_cal_hold: assert property ($rose(resetn) |->
        ##[0:4] (!dev_rst_oe_n) [*8])
        else $error("pin not held low during power-up calibration");
    a_cal_outputs_off: assert property (!dev_rst_oe_n &&
        !$past(dev_rst_oe_n) |-> !sample_strobe_out && sample_word == '0)
        else $error("sample output while calibrating");
    a_word_strobed: assert property ($changed(sample_word) &&
        sample_word != '0 |-> sample_strobe_out)
        else $error("word changed without strobe");
    a_over_saturates: assert property (over_range |->
        sample_word inside {10'h1FF, 10'h200, 10'h3FF, 10'h000})
        else $error("over-range word not full scale");
    a_halved_toggle: assert property ((!clock_halve_n) [*6] ##0
        sample_strobe_out |=> !sample_strobe_out)
        else $error("halved strobe not alternating");
    a_full_rate: assert property ((clock_halve_n && reset_pin_n) [*4]
        ##0 sample_strobe_out |=> sample_strobe_out)
        else $error("full rate strobe dropped");
    a_pulse_length: assert property ($rose(host_rst_oe_n) &&
        $past(resetn) |-> low_cnt_reg == 8'(LOW_CYCLES))
        else $error("forced reset pulse length wrong");
    a_recal_starts: assert property ($rose(host_rst_oe_n) &&
        $past(resetn) |-> ##[1:8] !dev_rst_oe_n)
        else $error("no calibration after forced reset");
endmodule // acs_link_asserts
`default_nettype wire

// File: dv/test_adc_control_and_output_sequencer.sv
/*
 * testbench: both link ends joined, capture end driven over axi4-lite.
 * assumes a 40 MHz clock and calibration shortened to 16 ticks.
 */
`timescale 1ns/100ps
`default_nettype none
module test_adc_control_and_output_sequencer;
    import acs_pkg::*;
    localparam int CAL_LEN = 16;
    localparam int LIMIT   = 20000;
    logic                       clock, resetn, irq, calibrating;
    logic signed [ANALOG_W-1:0] analog_in, ext_ref_level;
    logic                       ref_external_active;
    logic [4:0]                 awaddr, araddr;
    logic                       awvalid, awready, wvalid, wready;
    logic                       bvalid, bready, arvalid, arready;
    logic                       rvalid, rready;
    logic [31:0]                wdata, rdata, rd;
    logic [3:0]                 wstrb;
    logic [1:0]                 bresp, rresp, rsp;
    int                         n_mismatch, compares, cyc, n;

    acs_link_if link_if ();
    acs_converter #(.CAL_LEN(CAL_LEN)) u_acs_converter (.clock, .resetn,
        .analog_in, .ext_ref_level, .ref_external_active, .calibrating,
        .link(link_if.device));
    acs_capture u_acs_capture (.clock, .resetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq, .link(link_if.host));
    acs_link_asserts u_acs_link_asserts (.clock, .resetn,
        .dev_rst_oe_n(link_if.dev_rst_oe_n),
        .host_rst_oe_n(link_if.host_rst_oe_n),
        .reset_pin_n(link_if.reset_pin_n),
        .clock_halve_n(link_if.clock_halve_n),
        .sample_word(link_if.sample_word), .over_range(link_if.over_range),
        .sample_strobe_out(link_if.sample_strobe_out));

    // free-running clock
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the thousand or so cycles the run needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [4:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'h0;
    endtask

    // expected sample register: saturated code, flag in bit 10
    function automatic logic [31:0] code(input int v, input logic fmt_n);
        int s;
        s = (v > 511) ? 511 : (v < -512) ? -512 : v;
        code = {21'h0, v > 511 || v < -512,
                10'(s) ^ (fmt_n ? 10'h200 : 10'h0)};
    endfunction

    // program the selects, let the pipeline fill, read the last word
    task automatic sample(input logic [31:0] ctrl, input int v, rf);
        int e;
        analog_in <= ANALOG_W'(v);
        ext_ref_level <= ANALOG_W'(rf);
        axi_wr(5'(REG_CTRL), ctrl);
        repeat (2 * PIPE_TOTAL + 12) @(posedge clock);
        e = (ctrl[CTRL_FLOAT] || ctrl[CTRL_REF_EXT]) ? v - rf : v;
        axi_rd(5'(REG_SAMPLE));
        check(rd, code(e, ctrl[CTRL_FLOAT] | ctrl[CTRL_FMT_N]), "sample");
        check({31'h0, ref_external_active},
              {31'h0, ctrl[CTRL_FLOAT] | ctrl[CTRL_REF_EXT]}, "ref");
    endtask

    // calibration ends as the pin rises, then eight cycles pass before status is read
    task automatic wait_cal;
        wait (calibrating === 1'h1);
        wait (calibrating === 1'h0);
        repeat (8) @(posedge clock);
        axi_rd(5'(REG_STATUS));
        check(rd, 32'h0, "status idle");
    endtask

    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, analog_in, ext_ref_level} = '0;
        wstrb = 4'hF;
        {n_mismatch, compares, cyc, n} = '0;
        repeat (16) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        #1 check({31'h0, calibrating}, 32'h1, "cal at start");
        axi_rd(5'(REG_CTRL));
        check(rd, CTRL_RESET, "ctrl reset");
        check({30'h0, rsp}, {30'h0, AXI_OKAY}, "mapped read");
        axi_rd(5'(REG_STATUS));
        check(rd, 32'h1, "status cal");
        wait_cal();
        axi_rd(5'h14);
        check({30'h0, rsp}, {30'h0, AXI_SLVERR}, "unmapped read");
        check(rd, 32'h0, "unmapped data");
        axi_wr(5'h14, 32'h0000_00FF);
        check({30'h0, rsp}, {30'h0, AXI_SLVERR}, "unmapped write");
        sample(32'h02, 100, 0);
        sample(32'h02, -3, 0);
        sample(32'h06, -3, 0);
        sample(32'h02, 700, 0);
        sample(32'h06, -700, 0);
        sample(32'h0A, 100, 5);
        sample(32'h10, 100, 5);
        sample(32'h02, 0, 0);
        // step the input and count edges until the new word lands
        @(posedge clock);
        analog_in <= ANALOG_W'(77);
        do begin
            @(posedge clock);
            n++;
            #1;
        end while (link_if.sample_word !== 10'h04D && n < 100);
        // one edge takes the step, then the pipeline latency runs
        check(32'(n), 32'(PIPE_TOTAL + 1), "latency");
        // forced recalibration with the calibration-done interrupt
        axi_wr(REG_IRQ_MASK, 32'h0);
        axi_wr(5'(REG_IRQ_STAT), 32'h7);
        // halving moves the rate by half, so it goes with a recalibration
        axi_wr(5'(REG_CTRL), 32'h01);
        axi_rd(5'(REG_STATUS));
        check(rd & 32'h2, 32'h2, "pulse active");
        wait_cal();
        axi_rd(5'(REG_IRQ_STAT));
        check(rd & 32'h4, 32'h4, "cal done event");
        check({31'h0, irq}, 32'h0, "irq masked");
        axi_wr(REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1, "irq raised");
        axi_wr(5'(REG_IRQ_STAT), 32'h4);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0, "irq cleared");
        sample(32'h00, 200, 0);
        stop_test();
    end
endmodule // test_adc_control_and_output_sequencer
`default_nettype wire
